// File: bench/lcb_monitor.sv
`timescale 1ns/100ps
module lcb_monitor #(
   parameter int OSC_HALF = lcb_pkg::OSC_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_enable_pin,
   input wire logic dev_clk_oe_n,
   input wire logic sync_pin,
   input wire logic frame_tick,
   input wire logic blink_phase,
   input wire logic [1:0] blink_rate_sel,
   input wire logic blink_style,
   input wire logic [1:0] drive_mode,
   input wire logic [3:0] bp_active,
   input wire logic shown_bank,
   input wire logic display_on,
   input wire logic display_enable
);
   // ------------------------------------------------------------
   // gap counters
   // ------------------------------------------------------------
   // a gap is trusted only after one event under the same strap (and, for the blink gap,
   // the same rate): the dividers keep counting through a switch, so a gap across one mixes both settings
   localparam int TICK = 2 * OSC_HALF;
   int fgap;
   int bgap;
   logic fseen;
   logic bseen;
   logic osc_q;
   logic phase_q;
   logic [1:0] rate_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fgap <= 0;
         bgap <= 0;
         fseen <= 1'b0;
         bseen <= 1'b0;
         osc_q <= 1'b0;
         phase_q <= 1'b0;
         rate_q <= 2'h0;
      end else begin
         osc_q <= osc_enable_pin;
         phase_q <= blink_phase;
         rate_q <= blink_rate_sel;
         fgap <= frame_tick ? 1 : fgap + 1;
         bgap <= (blink_phase != phase_q) ? 1 : bgap + 1;
         if (osc_enable_pin != osc_q)
            fseen <= 1'b0;
         else if (frame_tick)
            fseen <= 1'b1;
         if (osc_enable_pin != osc_q || blink_rate_sel != rate_q)
            bseen <= 1'b0;
         else if (blink_phase != phase_q)
            bseen <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   osc_strap_a: assert property (
      $past(presetn) && $stable(osc_enable_pin)
      |-> dev_clk_oe_n == osc_enable_pin)
      else $error("clock driver does not follow the strap");
   frame_period_a: assert property (
      frame_tick && fseen |-> fgap == lcb_pkg::FRAME_DIV * TICK)
      else $error("frame period wrong");
   frame_sync_a: assert property (
      frame_tick |-> (##[0:2] !sync_pin) or (!$past(sync_pin)))
      else $error("no sync pulse at frame boundary");
   blink_period_a: assert property (
      blink_phase != phase_q && bseen && blink_rate_sel != 2'h0
      |-> bgap == (lcb_pkg::BLINK_DIV1 / 2 * TICK)
                  << (blink_rate_sel - 2'h1))
      else $error("blink period wrong");
   blink_off_a: assert property (
      blink_rate_sel == 2'h0 && $past(blink_rate_sel) == 2'h0
      && $past(blink_rate_sel, 2) == 2'h0 |-> !blink_phase)
      else $error("blink phase moves while blinking is off");
   mode_planes_a: assert property (
      $past(presetn, 2) && $stable(drive_mode)
      && $past(drive_mode, 2) == drive_mode
      |-> bp_active == (drive_mode == 2'h1 ? 4'h1 :
                        drive_mode == 2'h2 ? 4'h3 :
                        drive_mode == 2'h3 ? 4'h7 : 4'hf))
      else $error("active backplanes do not match drive mode");
   bank_fixed_a: assert property (
      $past(presetn, 2) && (drive_mode == 2'h0 || drive_mode == 2'h3)
      && $stable(drive_mode) && $past(drive_mode, 2) == drive_mode
      |-> !shown_bank)
      else $error("shown bank moves in three or four plane mode");
   alt_swap_a: assert property (
      blink_style && (drive_mode == 2'h1 || drive_mode == 2'h2)
      && $stable(blink_style) && $stable(drive_mode)
      && $changed(blink_phase) |-> ##[0:2] $changed(shown_bank))
      else $error("alternate blink does not swap the bank");
   normal_blink_a: assert property (
      display_enable && $stable(display_enable) && $stable(drive_mode)
      && (!blink_style || drive_mode == 2'h0 || drive_mode == 2'h3)
      && $stable(blink_style) && $changed(blink_phase)
      |-> ##[0:2] $changed(display_on))
      else $error("normal blink does not gate the display");
endmodule

// File: bench/test_lcd_command_and_blink_timing.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      check_count++; \
      if ((got) !== (ex)) begin \
         fails++; \
         $display("BAD %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module test_lcd_command_and_blink_timing;
   localparam int HALF = 2;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, rd_err;
   logic data_valid, bias_half, display_enable, display_on;
   logic in_bank, shown_bank, blink_style, blink_phase, frame_tick;
   logic [7:0] data_byte;
   logic [7:0] dv_last = 8'h00;
   logic [5:0] data_ptr;
   logic [1:0] subaddr, drive_mode, blink_rate_sel;
   logic [3:0] bp_active;
   logic ph_q = 1'b0, sb_q = 1'b0, on_q = 1'b0;
   logic [3:0] bp_exp [4] = '{4'hf, 4'h1, 4'h3, 4'h7};
   int divs [3] = '{lcb_pkg::BLINK_DIV1, lcb_pkg::BLINK_DIV2,
                    lcb_pkg::BLINK_DIV3};
   int fails = 0, check_count = 0, toggles = 0, frames = 0;
   int gap_b = 0, gap_f = 0, blink_gap = 0, frame_gap = 0;
   int sb_changes = 0, on_changes = 0, sb0, on0;

   initial begin
      forever #10 pclk = ~pclk;
   end

   lcb_if lcb_if_i();
   lcb_host #(.CLK_HALF(HALF)) lcb_host_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(lcb_if_i));
   lcb_dev #(.OSC_HALF(HALF)) lcb_dev_i (.pclk(pclk), .presetn(presetn),
      .link(lcb_if_i), .data_valid(data_valid), .data_byte(data_byte),
      .data_ptr(data_ptr), .subaddr(subaddr), .drive_mode(drive_mode),
      .bp_active(bp_active), .bias_half(bias_half),
      .display_enable(display_enable), .display_on(display_on),
      .in_bank(in_bank), .shown_bank(shown_bank),
      .blink_style(blink_style), .blink_rate_sel(blink_rate_sel),
      .blink_phase(blink_phase), .frame_tick(frame_tick));
   lcb_monitor #(.OSC_HALF(HALF)) lcb_monitor_i (.pclk(pclk),
      .presetn(presetn), .osc_enable_pin(lcb_if_i.osc_enable_pin),
      .dev_clk_oe_n(lcb_if_i.dev_clk_oe_n), .sync_pin(lcb_if_i.sync_pin),
      .frame_tick(frame_tick), .blink_phase(blink_phase),
      .blink_rate_sel(blink_rate_sel), .blink_style(blink_style),
      .drive_mode(drive_mode), .bp_active(bp_active),
      .shown_bank(shown_bank), .display_on(display_on),
      .display_enable(display_enable));

   // ------------------------------------------------------------
   // event counters
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      gap_b <= gap_b + 1;
      gap_f <= gap_f + 1;
      ph_q <= blink_phase;
      sb_q <= shown_bank;
      on_q <= display_on;
      if (blink_phase !== ph_q) begin
         toggles <= toggles + 1;
         blink_gap <= gap_b;
         gap_b <= 1;
      end
      if (shown_bank !== sb_q)
         sb_changes <= sb_changes + 1;
      if (display_on !== on_q)
         on_changes <= on_changes + 1;
      if (frame_tick === 1'b1) begin
         frames <= frames + 1;
         frame_gap <= gap_f;
         gap_f <= 1;
      end
      if (data_valid === 1'b1)
         dv_last <= data_byte;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // effects land within two cycles of the byte strobe
   task automatic send(input logic st, input logic [7:0] b);
      apb(lcb_pkg::REG_TX, 1'b1, {23'h0, st, b});
      repeat (3) @(posedge pclk);
   endtask

   function automatic int evc(input bit f);
      return f ? frames : toggles;
   endfunction

   task automatic wait_ev(input bit f, input int n);
      int t0;
      t0 = evc(f);
      while (evc(f) < t0 + n) begin
         @(posedge pclk);
      end
   endtask

   // counts bank and display changes over two whole blink phases
   task automatic swaps;
      wait_ev(0, 1);
      repeat (3) @(posedge pclk);
      sb0 = sb_changes;
      on0 = on_changes;
      wait_ev(0, 2);
      repeat (3) @(posedge pclk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (100000) @(posedge pclk);
      fails++;
      $display("BAD watchdog expected done seen timeout");
      report_and_stop;
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(lcb_pkg::REG_CTRL, 1'b0, 32'h0);
      `CHK("ctrl", 32'h2, rd)
      `CHK("bp_active", 4'hf, bp_active)
      `CHK("dev_clk_oe_n", 1'b0, lcb_if_i.dev_clk_oe_n)
      apb(12'h010, 1'b0, 32'h0);
      `CHK("slverr", 1'b1, rd_err)
      `CHK("unmapped", 32'h0, rd)
      send(1'b1, 8'h85);
      send(1'b0, 8'h27);
      `CHK("data_ptr", 6'h27, data_ptr)
      send(1'b0, 8'h62);
      `CHK("data_byte", 8'h62, dv_last)
      `CHK("subaddr", 2'h0, subaddr)
      send(1'b1, 8'h28);
      `CHK("data_ptr", 6'h27, data_ptr)
      for (int i = 0; i < 4; i++) begin
         send(1'b1, 8'h60 | i[7:0]);
         `CHK("subaddr", i[1:0], subaddr)
      end
      send(1'b1, 8'h64);
      send(1'b1, 8'h7c);
      `CHK("subaddr", 2'h3, subaddr)
      `CHK("data_ptr", 6'h27, data_ptr)
      for (int m = 0; m < 4; m++) begin
         send(1'b1, 8'h48 | m[7:0]);
         `CHK("drive_mode", m[1:0], drive_mode)
         `CHK("bp_active", bp_exp[m], bp_active)
      end
      send(1'b1, 8'h4d);
      `CHK("bias_half", 1'b1, bias_half)
      send(1'b1, 8'h41);
      `CHK("display_on", 1'b0, display_on)
      `CHK("bias_half", 1'b0, bias_half)
      send(1'b1, 8'h49);
      `CHK("display_on", 1'b1, display_on)
      send(1'b1, 8'h7b);
      `CHK("in_bank", 1'b1, in_bank)
      `CHK("shown_bank", 1'b1, shown_bank)
      send(1'b1, 8'h79);
      `CHK("in_bank", 1'b0, in_bank)
      `CHK("shown_bank", 1'b1, shown_bank)
      send(1'b1, 8'h48);
      send(1'b1, 8'h7a);
      `CHK("in_bank", 1'b0, in_bank)
      `CHK("shown_bank", 1'b0, shown_bank)
      for (int r = 1; r < 4; r++) begin
         send(1'b1, 8'h70 | r[7:0]);
         `CHK("blink_rate_sel", r[1:0], blink_rate_sel)
         wait_ev(0, 2);
         `CHK("blink_gap", divs[r - 1] * HALF, blink_gap)
      end
      send(1'b1, 8'h75);
      `CHK("blink_style", 1'b1, blink_style)
      swaps;
      `CHK("quad swaps", 0, sb_changes - sb0)
      `CHK("quad blinks", 2, on_changes - on0)
      send(1'b1, 8'h49);
      swaps;
      `CHK("static swaps", 2, sb_changes - sb0)
      `CHK("static blinks", 0, on_changes - on0)
      send(1'b1, 8'h70);
      repeat (8) @(posedge pclk);
      `CHK("blink_phase", 1'b0, blink_phase)
      wait_ev(1, 2);
      `CHK("frame_gap", lcb_pkg::FRAME_DIV * 2 * HALF, frame_gap)
      apb(lcb_pkg::REG_CTRL, 1'b1, 32'h3);
      repeat (4) @(posedge pclk);
      `CHK("osc pin", 1'b1, lcb_if_i.osc_enable_pin)
      `CHK("dev_clk_oe_n", 1'b1, lcb_if_i.dev_clk_oe_n)
      `CHK("host_clk_oe_n", 1'b0, lcb_if_i.host_clk_oe_n)
      wait_ev(1, 3);
      `CHK("frame_gap", lcb_pkg::FRAME_DIV * 2 * HALF, frame_gap)
      report_and_stop;
   end
endmodule

// File: hdl/lcb_dev.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - bit 7 set means next byte is command
// - drive mode field picks active backplanes
// - bit6 clear loads display pointer 0..39
// - prefix 11000 loads two-bit subaddress
// - bank command bit1 picks input bank
// - bank command bit0 picks displayed bank
// - bank command ignored in 1:3, 1:4
// - prefix 1110 sets blink style, rate
// - 1:3 and 1:4 always blink normally
// - blink periods 768, 1536, 3072 timing clocks
// - alternate blink swaps displayed bank each toggle
// - frame period is 24 timing clocks
// - osc strap low drives internal clock out
// - osc strap high takes clock from pin
// - other party must never stop the clock; host stops it when CTRL_CLKRUN_BIT is clear
// - sync pin keeps cascaded frames aligned
// - host blinks at odd rates via enable
module lcb_dev #(
   parameter int OSC_HALF = lcb_pkg::OSC_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   lcb_if.dev link,
   output logic data_valid,
   output logic [7:0] data_byte,
   output logic [5:0] data_ptr,
   output logic [1:0] subaddr,
   output logic [1:0] drive_mode,
   output logic [3:0] bp_active,
   output logic bias_half,
   output logic display_enable,
   output logic display_on,
   output logic in_bank,
   output logic shown_bank,
   output logic blink_style,
   output logic [1:0] blink_rate_sel,
   output logic blink_phase,
   output logic frame_tick
);

   if (OSC_HALF < 1 || OSC_HALF > 65535) begin : g_chk
      $error("lcb_dev: OSC_HALF out of range");
   end

   localparam logic [15:0] OSC_LAST = 16'(OSC_HALF - 1);
   localparam logic [4:0] FRAME_LAST = 5'(lcb_pkg::FRAME_DIV - 1);
   localparam logic [5:0] PTR_LAST = 6'(lcb_pkg::RAM_COLS - 1);

   // half blink period in timing-clock ticks
   function automatic logic [11:0] blink_half(input logic [1:0] rate);
      case (rate)
         2'h1: blink_half = 12'(lcb_pkg::BLINK_DIV1 / 2);
         2'h2: blink_half = 12'(lcb_pkg::BLINK_DIV2 / 2);
         2'h3: blink_half = 12'(lcb_pkg::BLINK_DIV3 / 2);
         default: blink_half = 12'h0;
      endcase
   endfunction

   // only static and 1:2 have a second bank
   function automatic logic two_banks(input logic [1:0] mode);
      two_banks = (mode == lcb_pkg::MODE_STATIC) ||
                  (mode == lcb_pkg::MODE_DUPLEX);
   endfunction

   lcb_pkg::lcb_dec_e dec_state;
   logic is_cmd;
   logic [7:0] b;
   logic [15:0] osc_cnt;
   logic osc_clk;
   logic clk_pin_q;
   logic sync_q;
   logic tick;
   logic [4:0] frame_cnt;
   logic [11:0] blink_cnt;
   logic out_bank;
   logic alt_active;

   assign b = link.byte_data;
   assign is_cmd = link.byte_valid &&
                   (link.xfer_start || dec_state == lcb_pkg::DEC_CMD);

   // ------------------------------------------------------------
   // command decoder
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_state <= lcb_pkg::DEC_IDLE;
      end else if (is_cmd) begin
         dec_state <= b[lcb_pkg::CONT_BIT] ? lcb_pkg::DEC_CMD
                                           : lcb_pkg::DEC_DATA;
      end
   end

   // data bytes stream out; bytes before any transfer start are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_valid <= 1'b0;
         data_byte <= 8'h00;
      end else begin
         data_valid <= link.byte_valid && !is_cmd &&
                       (dec_state == lcb_pkg::DEC_DATA);
         if (link.byte_valid && !is_cmd)
            data_byte <= b;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ptr <= lcb_pkg::RST_PTR;
         subaddr <= 2'h0;
         drive_mode <= lcb_pkg::RST_MODE;
         bias_half <= 1'b0;
         display_enable <= lcb_pkg::RST_ENABLE;
         in_bank <= 1'b0;
         out_bank <= 1'b0;
         blink_style <= 1'b0;
         blink_rate_sel <= lcb_pkg::RST_RATE;
      end else if (is_cmd) begin
         if (!b[6]) begin
            // pointer beyond the last column is not a valid address
            if (b[5:0] <= PTR_LAST) data_ptr <= b[5:0];
         end else if (b[6:5] == lcb_pkg::MODE_PREFIX) begin
            display_enable <= b[lcb_pkg::ENABLE_BIT];
            bias_half <= b[lcb_pkg::BIAS_BIT];
            drive_mode <= b[1:0];
         end else if (b[6:2] == lcb_pkg::SUBADDR_PREFIX) begin
            subaddr <= b[1:0];
         end else if (b[6:2] == lcb_pkg::BANK_PREFIX) begin
            if (two_banks(drive_mode)) begin
               in_bank <= b[lcb_pkg::IN_BANK_BIT];
               out_bank <= b[lcb_pkg::OUT_BANK_BIT];
            end
         end else if (b[6:3] == lcb_pkg::BLINK_PREFIX) begin
            blink_style <= b[lcb_pkg::STYLE_BIT];
            blink_rate_sel <= b[1:0];
         end
         // remaining prefixes fall through untouched
      end
   end

   // ------------------------------------------------------------
   // timing clock source
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt <= 16'h0;
         osc_clk <= 1'b0;
         clk_pin_q <= 1'b0;
         sync_q <= 1'b1;
      end else begin
         clk_pin_q <= link.clk_pin;
         sync_q <= link.sync_pin;
         if (osc_cnt >= OSC_LAST) begin
            osc_cnt <= 16'h0;
            osc_clk <= !osc_clk;
         end else begin
            osc_cnt <= osc_cnt + 16'h1;
         end
      end
   end

   // a tick is a rising edge of whichever timing clock is selected;
   // an external clock that stops freezes all timing
   always_comb begin
      if (link.osc_enable_pin)
         tick = link.clk_pin && !clk_pin_q;
      else
         tick = (osc_cnt >= OSC_LAST) && !osc_clk;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.dev_clk_o <= 1'b0;
         link.dev_clk_oe_n <= 1'b1;
      end else begin
         link.dev_clk_o <= osc_clk;
         link.dev_clk_oe_n <= link.osc_enable_pin;
      end
   end

   // ------------------------------------------------------------
   // frame counter and cascade sync
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_cnt <= 5'h0;
         frame_tick <= 1'b0;
         link.dev_sync_o <= 1'b0;
         link.dev_sync_oe_n <= 1'b1;
      end else begin
         frame_tick <= 1'b0;
         link.dev_sync_o <= 1'b0;
         if (!link.sync_pin && sync_q && link.dev_sync_oe_n) begin
            // another chip started its frame: restart ours with it
            frame_cnt <= 5'h0;
         end else if (tick) begin
            link.dev_sync_oe_n <= 1'b1;
            if (frame_cnt == FRAME_LAST) begin
               frame_cnt <= 5'h0;
               frame_tick <= 1'b1;
               link.dev_sync_oe_n <= 1'b0;
            end else begin
               frame_cnt <= frame_cnt + 5'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // blink generator and display outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_cnt <= 12'h0;
         blink_phase <= 1'b0;
      end else if (blink_rate_sel == 2'h0) begin
         blink_cnt <= 12'h0;
         blink_phase <= 1'b0;
      end else if (tick) begin
         if (blink_cnt >= blink_half(blink_rate_sel) - 12'h1) begin
            blink_cnt <= 12'h0;
            blink_phase <= !blink_phase;
         end else begin
            blink_cnt <= blink_cnt + 12'h1;
         end
      end
   end

   assign alt_active = blink_style && two_banks(drive_mode);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shown_bank <= 1'b0;
         display_on <= 1'b0;
         bp_active <= 4'h0;
      end else begin
         shown_bank <= two_banks(drive_mode) &&
                       (out_bank ^ (alt_active && blink_phase));
         display_on <= display_enable &&
                       !(!alt_active && blink_phase);
         case (drive_mode)
            lcb_pkg::MODE_STATIC: bp_active <= 4'h1;
            lcb_pkg::MODE_DUPLEX: bp_active <= 4'h3;
            lcb_pkg::MODE_TRIPLE: bp_active <= 4'h7;
            default: bp_active <= 4'hf;
         endcase
      end
   end

endmodule

// File: hdl/lcb_host.sv
`timescale 1ns/100ps
module lcb_host #(
   parameter int CLK_HALF = lcb_pkg::OSC_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   lcb_if.host link
);

   if (CLK_HALF < 1 || CLK_HALF > 65535) begin : g_chk
      $error("lcb_host: CLK_HALF out of range");
   end

   localparam logic [15:0] HALF_RST = 16'(CLK_HALF);

   logic [1:0] ctrl;
   logic [15:0] clk_half;
   logic [15:0] half_cnt;
   logic wr_ok;
   logic known;

   assign known = (paddr == lcb_pkg::REG_CTRL) ||
                  (paddr == lcb_pkg::REG_CLKDIV) ||
                  (paddr == lcb_pkg::REG_TX) ||
                  (paddr == lcb_pkg::REG_STATUS);
   assign wr_ok = psel && penable && pready && pwrite && known;

   // ------------------------------------------------------------
   // apb slave: answer in the first access cycle
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               lcb_pkg::REG_CTRL: prdata <= {30'h0, ctrl};
               lcb_pkg::REG_CLKDIV: prdata <= {16'h0, clk_half};
               lcb_pkg::REG_STATUS: prdata <= {30'h0, link.clk_pin,
                                               link.sync_pin};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= lcb_pkg::RST_CTRL;
         clk_half <= HALF_RST;
      end else if (wr_ok) begin
         if (paddr == lcb_pkg::REG_CTRL) ctrl <= pwdata[1:0];
         // zero would stop the clock, so it is held at one at least
         if (paddr == lcb_pkg::REG_CLKDIV)
            clk_half <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
      end
   end

   // ------------------------------------------------------------
   // byte link: one byte per tx write, sent the next cycle
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.byte_valid <= 1'b0;
         link.xfer_start <= 1'b0;
         link.byte_data <= 8'h00;
      end else begin
         link.byte_valid <= wr_ok && (paddr == lcb_pkg::REG_TX);
         link.xfer_start <= wr_ok && (paddr == lcb_pkg::REG_TX) &&
                            pwdata[lcb_pkg::TX_START_BIT];
         if (wr_ok && (paddr == lcb_pkg::REG_TX))
            link.byte_data <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // external timing clock and pin straps
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt <= 16'h0;
         link.host_clk_o <= 1'b0;
         link.host_clk_oe_n <= 1'b1;
         link.host_sync_oe_n <= 1'b1;
         link.osc_enable_pin <= 1'b0;
      end else begin
         link.osc_enable_pin <= ctrl[lcb_pkg::CTRL_OSC_BIT];
         // clock pin is an input of the device only while osc strap high
         link.host_clk_oe_n <= !(ctrl[lcb_pkg::CTRL_OSC_BIT] &&
                                 ctrl[lcb_pkg::CTRL_CLKRUN_BIT]);
         link.host_sync_oe_n <= 1'b1;
         if (half_cnt >= clk_half - 16'h1) begin
            half_cnt <= 16'h0;
            link.host_clk_o <= !link.host_clk_o;
         end else begin
            half_cnt <= half_cnt + 16'h1;
         end
      end
   end

endmodule

// File: hdl/lcb_if.sv
`timescale 1ns/100ps
interface lcb_if;
   logic xfer_start;
   logic byte_valid;
   logic [7:0] byte_data;
   logic osc_enable_pin;
   logic dev_clk_o;
   logic dev_clk_oe_n;
   logic host_clk_o;
   logic host_clk_oe_n;
   logic clk_pin;
   logic dev_sync_o;
   logic dev_sync_oe_n;
   logic host_sync_oe_n;
   logic sync_pin;

   // clock pin: whichever end enables its driver; low when nobody drives
   assign clk_pin = !dev_clk_oe_n ? dev_clk_o :
                    (!host_clk_oe_n ? host_clk_o : 1'b0);
   // sync is open drain with a pull-up: low while either end pulls it
   assign sync_pin = (dev_sync_oe_n || dev_sync_o) && host_sync_oe_n;

   modport dev (
      input xfer_start, byte_valid, byte_data, osc_enable_pin,
      input clk_pin, sync_pin,
      output dev_clk_o, dev_clk_oe_n, dev_sync_o, dev_sync_oe_n
   );
   modport host (
      output xfer_start, byte_valid, byte_data, osc_enable_pin,
      output host_clk_o, host_clk_oe_n, host_sync_oe_n,
      input clk_pin, sync_pin
   );
endinterface

// File: hdl/lcb_pkg.sv
package lcb_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int OSC_HZ = 4800;
   // half period of the internal oscillator in pclk cycles
   localparam int OSC_HALF = CLK_HZ / (2 * OSC_HZ);
   localparam int FRAME_DIV = 24;
   localparam int BLINK_DIV1 = 768;
   localparam int BLINK_DIV2 = 1536;
   localparam int BLINK_DIV3 = 3072;
   localparam int RAM_COLS = 40;

   // ------------------------------------------------------------
   // command byte layout
   // ------------------------------------------------------------
   localparam int CONT_BIT = 7;
   localparam logic [1:0] MODE_PREFIX = 2'h2;
   localparam logic [4:0] SUBADDR_PREFIX = 5'h18;
   localparam logic [4:0] BANK_PREFIX = 5'h1e;
   localparam logic [3:0] BLINK_PREFIX = 4'he;
   localparam int ENABLE_BIT = 3;
   localparam int BIAS_BIT = 2;
   localparam int IN_BANK_BIT = 1;
   localparam int OUT_BANK_BIT = 0;
   localparam int STYLE_BIT = 2;

   typedef enum logic [1:0] {
      MODE_QUAD = 2'h0,
      MODE_STATIC = 2'h1,
      MODE_DUPLEX = 2'h2,
      MODE_TRIPLE = 2'h3
   } lcb_mode_e;

   typedef enum logic [1:0] {
      DEC_IDLE = 2'h0,
      DEC_CMD = 2'h1,
      DEC_DATA = 2'h2
   } lcb_dec_e;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [1:0] RST_MODE = 2'h0;
   localparam logic RST_ENABLE = 1'b0;
   localparam logic [5:0] RST_PTR = 6'h00;
   localparam logic [1:0] RST_RATE = 2'h0;

   // ------------------------------------------------------------
   // host register map
   // ------------------------------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_CLKDIV = 12'h004;
   localparam logic [11:0] REG_TX = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00c;
   localparam int CTRL_OSC_BIT = 0;
   localparam int CTRL_CLKRUN_BIT = 1;
   localparam int TX_START_BIT = 8;
   localparam logic [1:0] RST_CTRL = 2'h2;

endpackage
